// [hw/asp_defs.vh]
// Register offsets, control field positions and reset values of the serial port.
// Assumes inclusion by the port and its baud timer only.
`ifndef ASP_DEFS_VH
`define ASP_DEFS_VH
`define ASP_OFS_CTRL 12'h000
`define ASP_OFS_DATA 12'h004
`define ASP_OFS_BAUD 12'h008
`define ASP_BIT_MODE 7
`define ASP_BIT_RSVD 6
`define ASP_BIT_FILT 5
`define ASP_BIT_REN 4
`define ASP_BIT_TX9 3
`define ASP_BIT_RX9 2
`define ASP_BIT_TI 1
`define ASP_BIT_RI 0
`define ASP_BIT_RUN 8
`define ASP_RST_CTRL 8'h40
`define ASP_RST_RELOAD 8'h00
`define ASP_DATA_BITS 4'h8
`define ASP_TIMER_MAX 8'hFF
`endif

// [hw/asp_baud_timer.v]
// Eight-bit auto-reload timer that gives one overflow pulse per wrap.
// Assumes one clock; run and reload value come from the port's registers.
`timescale 1ns/1ps
`include "asp_defs.vh"
module asp_baud_timer #(
  parameter WIDTH = 8
) (
  input wire clk_sys,
  input wire reset,
  input wire run,
  input wire force_reload,
  input wire [WIDTH-1:0] reload_value,
  output reg overflow
);
  reg [WIDTH-1:0] count;
  // A forced reload restarts the period so a receiver can align to a start edge.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      count <= {WIDTH{1'b0}};
      overflow <= 1'b0;
    end else if (force_reload) begin
      count <= reload_value;
      overflow <= 1'b0;
    end else if (run) begin
      if (count == {WIDTH{1'b1}}) begin
        count <= reload_value;
        overflow <= 1'b1;
      end else begin
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        overflow <= 1'b0;
      end
    end else begin
      overflow <= 1'b0;
    end
  end
endmodule

// [hw/asp_serial_port.v]
// Full-duplex asynchronous serial port with 8-bit and 9-bit frames and an APB slave.
// Assumes APB master on clk_sys and a serial line synchronous to clk_sys.
// Behaviour
// - One control bit selects 8-bit or 9-bit framing.
// - 8-bit frame is start, eight data bits, one stop: ten bit times.
// - Data bits travel least significant bit first both ways.
// - Writing the data buffer starts a transmit frame.
// - Transmit-done flag sets when the stop bit time begins.
// - Reception only happens while receive enable is one; the code checks it only at the start edge, so a started frame still completes.
// - 8-bit mode stores only if receive flag clear and, when filtering, stop is one.
// - Successful 8-bit store loads byte, stop bit into ninth flag, sets receive flag.
// - On overrun the held byte stays and the new frame is dropped.
// - Failed store leaves buffer, ninth flag and receive flag untouched.
// - Interrupt request whenever transmit-done or receive flag is set.
// - 9-bit frame is start, eight data, ninth bit, stop: eleven bit times.
// - 9-bit mode sends the software ninth transmit bit.
// - 9-bit mode puts received ninth bit into ninth flag, ignores stop.
// - 9-bit mode stores only if receive flag clear and, when filtering, ninth is one.
// - Data location writes go to transmit, reads return the receive buffer.
// - Flags are cleared only by software writes.
// - Bit rate is half the timer overflow; receive timer reloads on start.
// - Mode bit zero means 8-bit framing, one means 9-bit framing.
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "asp_defs.vh"
module asp_serial_port #(
  parameter [7:0] RELOAD_DEFAULT = `ASP_RST_RELOAD
) (
  input wire clk_sys,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire rx_line,
  output reg tx_line,
  output reg serial_irq
);
  localparam TX_IDLE = 2'b00;
  localparam TX_START = 2'b01;
  localparam TX_SHIFT = 2'b10;
  localparam TX_STOP = 2'b11;
  localparam RX_IDLE = 2'b00;
  localparam RX_START = 2'b01;
  localparam RX_SHIFT = 2'b10;
  localparam RX_STOP = 2'b11;

  reg frame_length_select_bit;
  reg address_filter_enable;
  reg receive_enable;
  reg tx_ninth_bit;
  reg rx_ninth_bit;
  reg transmit_done_flag;
  reg receive_flag;
  reg [7:0] serial_data_buffer;
  reg [7:0] baud_reload_value;
  reg timer_run;

  reg [1:0] tx_state;
  reg [8:0] tx_shift;
  reg [3:0] tx_count;
  reg tx_half;
  reg [1:0] rx_state;
  reg [8:0] rx_shift;
  reg [3:0] rx_count;
  reg rx_half;
  reg rx_prev;

  wire tx_ovf;
  wire rx_ovf;
  wire access;
  wire wr_ctrl;
  wire wr_data;
  wire start_edge;
  wire tx_tick;
  wire rx_sample;
  wire [3:0] frame_bits;
  reg next_ti_set;
  reg next_ri_set;
  reg store_ok;
  reg stored_ninth;

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr == `ASP_OFS_CTRL) || (addr == `ASP_OFS_DATA) || (addr == `ASP_OFS_BAUD);
    end
  endfunction

  // One wait state lets prdata and pready both come straight from flops.
  assign access = psel && penable && pready;
  assign wr_ctrl = access && pwrite && (paddr == `ASP_OFS_CTRL);
  assign wr_data = access && pwrite && (paddr == `ASP_OFS_DATA);
  assign start_edge = receive_enable && (rx_state == RX_IDLE) && rx_prev && !rx_line;
  assign tx_tick = tx_ovf && tx_half;
  assign rx_sample = rx_ovf && rx_half;
  // Nine data bits in 9-bit mode, eight otherwise.
  assign frame_bits = frame_length_select_bit ? (`ASP_DATA_BITS + 4'h1) : `ASP_DATA_BITS;

  asp_baud_timer #(.WIDTH(8)) u_tx_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(timer_run),
    .force_reload(1'b0),
    .reload_value(baud_reload_value),
    .overflow(tx_ovf)
  );

  asp_baud_timer #(.WIDTH(8)) u_rx_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .run(timer_run),
    .force_reload(start_edge),
    .reload_value(baud_reload_value),
    .overflow(rx_ovf)
  );

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped(paddr);
        prdata <= 32'h00000000;
        if (!pwrite) begin
          case (paddr)
            `ASP_OFS_CTRL: prdata <= {24'h000000, frame_length_select_bit, 1'b1, address_filter_enable,
              receive_enable, tx_ninth_bit, rx_ninth_bit, transmit_done_flag, receive_flag};
            `ASP_OFS_DATA: prdata <= {24'h000000, serial_data_buffer};
            `ASP_OFS_BAUD: prdata <= {23'h000000, timer_run, baud_reload_value};
            default: prdata <= 32'h00000000;
          endcase
        end
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Control fields; the status flags are handled with their hardware set below.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      frame_length_select_bit <= 1'b0;
      address_filter_enable <= 1'b0;
      receive_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      baud_reload_value <= RELOAD_DEFAULT;
      timer_run <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        frame_length_select_bit <= pwdata[`ASP_BIT_MODE];
        address_filter_enable <= pwdata[`ASP_BIT_FILT];
        receive_enable <= pwdata[`ASP_BIT_REN];
        tx_ninth_bit <= pwdata[`ASP_BIT_TX9];
      end
      if (access && pwrite && (paddr == `ASP_OFS_BAUD)) begin
        baud_reload_value <= pwdata[7:0];
        timer_run <= pwdata[`ASP_BIT_RUN];
      end
    end
  end

  // Transmitter: the timer overflow divided by two paces the bits.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tx_state <= TX_IDLE;
      tx_shift <= 9'h000;
      tx_count <= 4'h0;
      tx_half <= 1'b0;
      tx_line <= 1'b1;
      next_ti_set <= 1'b0;
    end else begin
      next_ti_set <= 1'b0;
      if (tx_ovf) begin
        tx_half <= !tx_half;
      end
      case (tx_state)
        TX_IDLE: begin
          tx_line <= 1'b1;
          // A write while a frame is in flight is dropped; software waits for the done flag.
          if (wr_data) begin
            tx_shift <= {tx_ninth_bit, pwdata[7:0]};
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          if (tx_tick) begin
            tx_line <= 1'b0;
            tx_count <= 4'h0;
            tx_state <= TX_SHIFT;
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            if (tx_count == frame_bits) begin
              tx_line <= 1'b1;
              next_ti_set <= 1'b1;
              tx_state <= TX_STOP;
            end else begin
              tx_line <= tx_shift[0];
              tx_shift <= {1'b0, tx_shift[8:1]};
              tx_count <= tx_count + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tx_tick) begin
            tx_state <= TX_IDLE;
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // Store decision taken as the stop bit is sampled.
  always @* begin
    stored_ninth = frame_length_select_bit ? rx_shift[8] : rx_line;
    store_ok = !receive_flag && (!address_filter_enable || stored_ninth);
  end

  // Receiver: the forced reload puts each overflow pair at mid-bit.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rx_state <= RX_IDLE;
      rx_shift <= 9'h000;
      rx_count <= 4'h0;
      rx_half <= 1'b0;
      rx_prev <= 1'b1;
      serial_data_buffer <= 8'h00;
      rx_ninth_bit <= 1'b0;
      next_ri_set <= 1'b0;
    end else begin
      rx_prev <= rx_line;
      next_ri_set <= 1'b0;
      if (rx_ovf) begin
        rx_half <= !rx_half;
      end
      case (rx_state)
        RX_IDLE: begin
          if (start_edge) begin
            rx_half <= 1'b1;
            rx_count <= 4'h0;
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (rx_ovf) begin
            rx_half <= 1'b0;
            rx_state <= rx_line ? RX_IDLE : RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          if (rx_sample) begin
            // Bits enter at the top so the first one ends up lowest.
            if (frame_length_select_bit) begin
              rx_shift <= {rx_line, rx_shift[8:1]};
            end else begin
              rx_shift <= {1'b0, rx_line, rx_shift[7:1]};
            end
            rx_count <= rx_count + 4'h1;
            if (rx_count == frame_bits - 4'h1) begin
              rx_state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_sample) begin
            rx_state <= RX_IDLE;
            if (store_ok) begin
              serial_data_buffer <= rx_shift[7:0];
              rx_ninth_bit <= stored_ninth;
              next_ri_set <= 1'b1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // Software writes the flag values; a hardware set in the same cycle wins.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      transmit_done_flag <= 1'b0;
      receive_flag <= 1'b0;
      serial_irq <= 1'b0;
    end else begin
      if (next_ti_set) begin
        transmit_done_flag <= 1'b1;
      end else if (wr_ctrl) begin
        transmit_done_flag <= pwdata[`ASP_BIT_TI];
      end
      if (next_ri_set) begin
        receive_flag <= 1'b1;
      end else if (wr_ctrl) begin
        receive_flag <= pwdata[`ASP_BIT_RI];
      end
      serial_irq <= transmit_done_flag || receive_flag;
    end
  end
endmodule

// [tb/asp_props.sv]
// Checker of the serial port's bus and line ports.
// Assumes it is bound to asp_serial_port and sees only its ports.
`timescale 1ns/1ps
module asp_props (
  input wire clk_sys,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rx_line,
  input wire tx_line,
  input wire serial_irq
);
  reg wr_took;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Flags may only fall after a completed write, so remember the last one.
  always @(posedge clk_sys or posedge reset) begin
    if (reset)
      wr_took <= 1'b0;
    else
      wr_took <= psel && penable && pwrite && pready;
  end
  sequence acc_first;
    psel && penable && !pready;
  endsequence
  sequence acc_done;
    psel && penable && pready;
  endsequence
  chk_one_wait: assert property ($rose(penable) && psel |-> acc_first ##1 acc_done)
    else $error("bus answer not after one wait state");
  chk_ready_one: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_ready_sel: assert property (pready |-> psel && penable)
    else $error("pready outside an access");
  chk_err_pair: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  chk_err_zero: assert property ((acc_done and (pslverr && !pwrite)) |-> prdata == 32'h0)
    else $error("refused read not zero");
  chk_ctrl_fixed: assert property ((acc_done and (!pwrite && paddr == 12'h000)) |-> prdata[31:8] == 24'h0 && prdata[6])
    else $error("control read bits wrong");
  chk_start_bit: assert property ($fell(tx_line) |=> !tx_line)
    else $error("start bit too short");
  chk_irq_clear: assert property ($fell(serial_irq) |-> $past(wr_took))
    else $error("interrupt fell without a write");
endmodule

// [tb/asp_far_node.sv]
// Remote serial node: sends frames on rx_line and captures frames from tx_line.
// Assumes a bit time of BIT clk_sys cycles; the line idles high like a pulled-up wire.
`timescale 1ns/1ps
module asp_far_node #(
  parameter BIT = 8
) (
  input wire clk_sys,
  input wire tx_line,
  output reg rx_line
);
  reg [10:0] got;
  initial rx_line = 1'b1;
  task automatic send(input [10:0] frm, input integer n);
    integer i;
    for (i = 0; i < n * BIT; i = i + 1) begin
      @(posedge clk_sys);
      rx_line <= frm[i / BIT];
    end
    @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask
  // A low pulse far shorter than half a bit, which the receiver must not take as a start.
  task automatic glitch;
    @(posedge clk_sys);
    rx_line <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rx_line <= 1'b1;
  endtask
  // Samples mid-bit; an unused top bit stays one so 10-bit frames compare whole.
  task automatic grab(input integer n);
    integer i;
    got = 11'h7FF;
    while (tx_line !== 1'b0) @(posedge clk_sys);
    repeat (BIT / 2) @(posedge clk_sys);
    for (i = 0; i < n; i = i + 1) begin
      got[i] = tx_line;
      repeat (BIT) @(posedge clk_sys);
    end
  endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench of the serial port in both frame modes.
// Assumes an 8-cycle bit time from reload 0xFC with the timer running.
`timescale 1ns/1ps
module tb_top;
  reg clk_sys, reset, psel, penable, pwrite, n9, m, r8, er;
  reg [11:0] paddr;
  reg [31:0] pwdata, rd;
  reg [7:0] b;
  wire [31:0] prdata;
  wire pready, pslverr, rx_line, tx_line, serial_irq;
  integer failures, tests_run, t;
  asp_serial_port dut (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_line(rx_line), .tx_line(tx_line), .serial_irq(serial_irq));
  asp_far_node #(.BIT(8)) far (.clk_sys(clk_sys), .tx_line(tx_line), .rx_line(rx_line));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  function [31:0] ctl(input md, fl, rn, t8, rb, ti, ri);
    ctl = {24'h0, md, 1'b1, fl, rn, t8, rb, ti, ri};
  endfunction
  function [10:0] fr(input md, input [7:0] d, input nb, input sb);
    fr = {sb, md ? nb : sb, d, 1'b0};
  endfunction
  task check(input string nm, input [31:0] exp, input [31:0] got);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    failures = failures + 1;
    wrap_up;
  end
  initial begin
    failures = 0;
    tests_run = 0;
    r8 = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = 0;
    b = $urandom(18);
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    apb(0, 12'h000, 0); check("ctrl", 32'h40, rd);
    apb(0, 12'h008, 0); check("baud", 32'h0, rd);
    apb(1, 12'h00C, 1); check("slverr", 1, {31'h0, er});
    apb(0, 12'h00C, 0);
    check("slverr rd", 1, {31'h0, er});
    check("unmapped rd", 32'h0, rd);
    apb(1, 12'h008, 32'h1FC);
    $display("register test done");
    for (t = 0; t < 2; t = t + 1) begin
      m = t;
      n9 = $urandom;
      b = $urandom;
      apb(1, 12'h000, ctl(m, 0, 1, n9, 0, 0, 0));
      fork
        far.grab(m ? 11 : 10);
        apb(1, 12'h004, {24'h0, b});
      join
      check("tx frame", fr(m, b, n9, 1), far.got);
      apb(0, 12'h000, 0); check("ti", ctl(m, 0, 1, n9, r8, 1, 0), rd);
      check("irq", 1, {31'h0, serial_irq});
      far.send(fr(m, b, 1, 1), m ? 11 : 10);
      far.send(fr(m, ~b, 0, 1), m ? 11 : 10);
      r8 = 1'b1;
      apb(0, 12'h004, 0); check("rx data", b, rd);
      apb(0, 12'h000, 0); check("rx flags", ctl(m, 0, 1, n9, 1, 1, 1), rd);
      apb(1, 12'h000, ctl(m, 1, 1, n9, 0, 0, 0));
      @(posedge clk_sys);
      check("irq off", 0, {31'h0, serial_irq});
      far.send(fr(m, ~b, 0, m), m ? 11 : 10);
      apb(0, 12'h000, 0); check("refused", ctl(m, 1, 1, n9, 1, 0, 0), rd);
      far.glitch;
      repeat (100) @(posedge clk_sys);
      apb(0, 12'h000, 0);
      check("glitch", ctl(m, 1, 1, n9, 1, 0, 0), rd);
      b = $urandom;
      far.send(fr(m, b, 1, !m), m ? 11 : 10);
      apb(0, 12'h004, 0); check("address", b, rd);
      apb(1, 12'h000, ctl(m, 0, 0, n9, 0, 0, 0));
      far.send(fr(m, ~b, 1, 1), m ? 11 : 10);
      apb(0, 12'h000, 0); check("disabled", ctl(m, 0, 0, n9, 1, 0, 0), rd);
      $display("frame mode %0d test done", m);
    end
    wrap_up;
  end
endmodule
bind asp_serial_port asp_props chk (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_line(rx_line), .tx_line(tx_line), .serial_irq(serial_irq));
